//--- hw/sdrbc_pkg.sv
// Summary of operation
// - Select low with all three strobes high is a no-operation.
// - Row strobe low alone is ACTIVE, only to an idle bank.
// - AUTO REFRESH and LOAD MODE REGISTER only while every bank is idle.
// - Column strobe low, write high is READ; bank row active, read or write.
// - Column and write strobe low is WRITE; bank row active, read or write.
// - Commands count only with clock enable high on both edges.
// - No command to a precharging, activating or auto-precharging bank.
// - After AUTO REFRESH only inhibit or no-operation until refresh time.
// - After LOAD MODE REGISTER only inhibit or no-operation until mode delay.
// - After precharge-all only inhibit or no-operation until precharge time.
// - Precharge-all only when every bank may be precharged.
// - With bank n idle, bank m takes whatever its own state allows.
// - Bank n activating, active or precharging: others take ACT, RD, WR, PRE.
// - Bank n bursting: others take ACT, PRE, and RD or WR either way.
// - Never produce a state and command pairing the decode tables omit.
// - Address bit ten on READ or WRITE turns auto precharge on.
// - Address bit ten on PRECHARGE selects all banks, ignoring bank bits.
package sdrbc_pkg;
  // Clock and device timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PRECHARGE_TIME_NS = 20;
  localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS = 66;
  localparam int MODE_LOAD_DELAY_NS = 10;
  // Least times, rounded up to whole cycles
  localparam int PRECHARGE_CYCLES =
    (PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACTIVATE_CYCLES =
    (ACTIVATE_TO_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_CYCLES =
    (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MODE_LOAD_CYCLES =
    (MODE_LOAD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BURST_LEN = 4;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 13;
  localparam int BANKS = 4;
  localparam int AP_ADDR_BIT = 10;
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int CTRL_CKE_BIT = 0;
  localparam logic CTRL_CKE_RST = 1'b1;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_AP_BIT = 8;
  localparam int STAT_ERR_BIT = 1;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_ACT = 3'h1, OP_RD = 3'h2, OP_WR = 3'h3,
    OP_PRE = 3'h4, OP_BST = 3'h5, OP_REF = 3'h6, OP_LMR = 3'h7
  } sdrbc_op_t;

  typedef enum logic [3:0] {
    BK_IDLE = 4'h0, BK_ACTIVATING = 4'h1, BK_ROW = 4'h2, BK_READ = 4'h3,
    BK_WRITE = 4'h4, BK_READ_AP = 4'h5, BK_WRITE_AP = 4'h6,
    BK_PRECHARGING = 4'h7
  } sdrbc_bank_st_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdrbc_pins_t;

  // Row, column and write strobe levels for each command
  function automatic logic [2:0] sdrbc_strobes(sdrbc_op_t op);
    logic [2:0] s;
    s = 3'h7;
    unique case (op)
      OP_NOP: s = 3'h7;
      OP_ACT: s = 3'h3;
      OP_RD: s = 3'h5;
      OP_WR: s = 3'h4;
      OP_PRE: s = 3'h2;
      OP_BST: s = 3'h6;
      OP_REF: s = 3'h1;
      OP_LMR: s = 3'h0;
    endcase
    return s;
  endfunction
endpackage

//--- hw/sdrbc_bank_trk.sv
`timescale 1ns/10ps
`default_nettype none
module sdrbc_bank_trk
  import sdrbc_pkg::*;
#(
  parameter int PRECHARGE_TIME = PRECHARGE_CYCLES,
  parameter int ACTIVATE_TO_ACCESS_DELAY = ACTIVATE_CYCLES,
  parameter int BURST = BURST_LEN
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic go,
  input wire sdrbc_op_t op,
  input wire logic ap,
  input wire logic cut,
  input wire logic bterm,
  output var sdrbc_bank_st_t state
);
  sdrbc_bank_st_t st_q;
  sdrbc_bank_st_t st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic bursting;

  // Counts load the full figure: the device registers one edge later
  assign bursting = (st_q == BK_READ) || (st_q == BK_WRITE);
  assign state = st_q;

  // Bank state model of the device
  always_comb
  begin
    st_d = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    if (go)
    begin
      unique case (op)
        OP_ACT:
        begin
          st_d = BK_ACTIVATING;
          cnt_d = CNT_W'(ACTIVATE_TO_ACCESS_DELAY);
        end
        OP_RD, OP_WR:
        begin
          if (ap)
          begin
            st_d = (op == OP_RD) ? BK_READ_AP : BK_WRITE_AP;
            cnt_d = CNT_W'(BURST + PRECHARGE_TIME);
          end
          else
          begin
            st_d = (op == OP_RD) ? BK_READ : BK_WRITE;
            cnt_d = CNT_W'(BURST);
          end
        end
        OP_PRE:
        begin
          if (st_q != BK_IDLE)
          begin
            st_d = BK_PRECHARGING;
            cnt_d = CNT_W'(PRECHARGE_TIME);
          end
        end
        default: ;
      endcase
    end
    else if (bterm && bursting)
      st_d = BK_ROW;
    else if (cut && bursting)
      st_d = BK_ROW;
    else if (cut && (st_q == BK_READ_AP || st_q == BK_WRITE_AP))
      cnt_d = (cnt_q > CNT_W'(PRECHARGE_TIME)) ? CNT_W'(PRECHARGE_TIME) : cnt_d;
    else if (cnt_q == '0)
    begin
      unique case (st_q)
        BK_ACTIVATING, BK_READ, BK_WRITE: st_d = BK_ROW;
        BK_PRECHARGING, BK_READ_AP, BK_WRITE_AP: st_d = BK_IDLE;
        default: ;
      endcase
    end
  end

  // State register, frozen by the clock enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= BK_IDLE;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // sdrbc_bank_trk
`default_nettype wire

//--- hw/sdrbc_host.sv
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sdrbc_host
  import sdrbc_pkg::*;
#(
  parameter int PRECHARGE_TIME = PRECHARGE_CYCLES,
  parameter int ACTIVATE_TO_ACCESS_DELAY = ACTIVATE_CYCLES,
  parameter int REFRESH_CYCLE_TIME = REFRESH_CYCLES,
  parameter int MODE_LOAD_DELAY = MODE_LOAD_CYCLES,
  parameter int BURST = BURST_LEN
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output var sdrbc_pins_t pins
);
  // Counters must hold the longest load
  if (PRECHARGE_TIME < 1 || ACTIVATE_TO_ACCESS_DELAY < 1 || REFRESH_CYCLE_TIME < 1 || MODE_LOAD_DELAY < 1 || BURST < 1 ||
      BURST + PRECHARGE_TIME > 255 || REFRESH_CYCLE_TIME > 255 || ACTIVATE_TO_ACCESS_DELAY > 255)
  begin : g_bad_timing
    $error("sdrbc_host: timing counts out of range");
  end

  logic aph_valid_q;
  logic aph_write_q;
  logic [7:0] aph_addr_q;
  logic [31:0] rdata_q;
  logic ctrl_cke_q;
  logic [ADDR_W-1:0] addr_q;
  logic [8:0] cmd_q;
  logic err_q;
  logic err_d;
  logic [CNT_W-1:0] gcnt_q;
  logic [CNT_W-1:0] gcnt_d;
  logic [1:0] last_bank_q;
  logic last_valid_q;
  sdrbc_pins_t pins_d;
  logic ap_take;
  logic dp_write;
  logic wr_ctrl;
  logic wr_addr;
  logic wr_cmd;
  logic wr_stat;
  logic sel_ctrl;
  logic sel_addr;
  logic sel_cmd;
  logic sel_stat;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;
  sdrbc_op_t req_op;
  logic [1:0] req_bank;
  logic req_ap;
  logic req_rw;
  logic req_all;
  logic legal;
  logic issue;
  logic refuse;
  logic gbusy;
  logic cke_ok;
  logic all_idle;
  logic all_pre_ok;
  logic sel_idle;
  logic sel_open;
  logic sel_pre_ok;
  logic last_burst;
  logic [BANKS-1:0] bk_idle;
  logic [BANKS-1:0] bk_open;
  logic [BANKS-1:0] bk_pre_ok;
  logic [BANKS-1:0] bk_burst;
  logic [BANKS-1:0] bk_go;
  logic [BANKS-1:0] bk_cut;
  logic [BANKS-1:0] bk_bterm;
  logic [4*BANKS-1:0] bk_vec;
  sdrbc_bank_st_t bank_st [BANKS];

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign ap_take = hsel && hready && htrans[1];
  assign dp_write = aph_valid_q && aph_write_q;

  // Read decode on the address phase; unmapped words read zero
  assign sel_ctrl = haddr[7:0] == REG_CTRL;
  assign sel_addr = haddr[7:0] == REG_ADDR;
  assign sel_cmd = haddr[7:0] == REG_CMD;
  assign sel_stat = haddr[7:0] == REG_STAT;
  assign rd_mux = sel_ctrl ? (32'(ctrl_cke_q) << CTRL_CKE_BIT) :
                  sel_addr ? 32'(addr_q) :
                  sel_cmd ? 32'(cmd_q) :
                  sel_stat ? stat_word : 32'h0000_0000;
  assign stat_word = 32'({bk_vec, 1'b0, cke_ok, err_q, gbusy});

  // Write decode in the data phase
  assign wr_ctrl = dp_write && aph_addr_q == REG_CTRL;
  assign wr_addr = dp_write && aph_addr_q == REG_ADDR;
  assign wr_cmd = dp_write && aph_addr_q == REG_CMD;
  assign wr_stat = dp_write && aph_addr_q == REG_STAT;

  // Command fields straight from the write data
  assign req_op = sdrbc_op_t'(hwdata[CMD_OP_LSB +: 3]);
  assign req_bank = hwdata[CMD_BANK_LSB +: 2];
  assign req_ap = hwdata[CMD_AP_BIT];
  assign req_rw = (req_op == OP_RD) || (req_op == OP_WR);
  assign req_all = (req_op == OP_PRE) && req_ap;

  // Per-bank trackers and their summaries
  for (genvar i = 0; i < BANKS; i++)
  begin : g_bank
    assign bk_idle[i] = bank_st[i] == BK_IDLE;
    assign bk_burst[i] = (bank_st[i] == BK_READ) || (bank_st[i] == BK_WRITE);
    assign bk_open[i] = bk_burst[i] || (bank_st[i] == BK_ROW);
    assign bk_pre_ok[i] = bk_open[i] || bk_idle[i];
    assign bk_vec[4*i +: 4] = bank_st[i];
    assign bk_go[i] = issue && ((req_bank == 2'(i)) || req_all);
    assign bk_cut[i] = issue && req_rw && (req_bank != 2'(i));
    assign bk_bterm[i] = issue && (req_op == OP_BST) &&
                         (last_bank_q == 2'(i));
    sdrbc_bank_trk #(
      .PRECHARGE_TIME(PRECHARGE_TIME),
      .ACTIVATE_TO_ACCESS_DELAY(ACTIVATE_TO_ACCESS_DELAY),
      .BURST(BURST)
    ) u_trk (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .go(bk_go[i]),
      .op(req_op),
      .ap(req_ap),
      .cut(bk_cut[i]),
      .bterm(bk_bterm[i]),
      .state(bank_st[i])
    );
  end

  // Legality of the requested command against the bank model
  assign all_idle = &bk_idle;
  assign all_pre_ok = &bk_pre_ok;
  assign sel_idle = bk_idle[req_bank];
  assign sel_open = bk_open[req_bank];
  assign sel_pre_ok = bk_pre_ok[req_bank];
  assign last_burst = last_valid_q && bk_burst[last_bank_q];
  assign gbusy = gcnt_q != '0;
  assign cke_ok = ctrl_cke_q && pins.cke;

  // Anything the decode tables omit is refused
  always_comb
  begin
    unique case (req_op)
      OP_NOP: legal = 1'b1;
      OP_ACT: legal = sel_idle;
      OP_RD, OP_WR: legal = sel_open;
      OP_PRE: legal = req_all ? all_pre_ok : sel_pre_ok;
      OP_BST: legal = last_burst;
      OP_REF, OP_LMR: legal = all_idle;
    endcase
  end

  assign issue = ce && wr_cmd && legal && cke_ok && !gbusy;
  assign refuse = ce && wr_cmd && !issue;
  assign err_d = refuse || (err_q && !(wr_stat && hwdata[STAT_ERR_BIT]));

  // Next pin drive: one command cycle, then inhibit
  always_comb
  begin
    pins_d = '0;
    pins_d.cke = ctrl_cke_q;
    pins_d.cs_n = 1'b1;
    {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = 3'h7;
    if (issue)
    begin
      pins_d.cs_n = 1'b0;
      {pins_d.ras_n, pins_d.cas_n, pins_d.we_n} = sdrbc_strobes(req_op);
      pins_d.ba = req_bank;
      pins_d.addr = addr_q;
      if (req_rw || req_op == OP_PRE)
        pins_d.addr[AP_ADDR_BIT] = req_ap;
    end
  end

  // Quiet period after refresh, mode load and precharge-all
  always_comb
  begin
    gcnt_d = gbusy ? gcnt_q - 1'b1 : gcnt_q;
    if (issue && req_op == OP_REF)
      gcnt_d = CNT_W'(REFRESH_CYCLE_TIME);
    else if (issue && req_op == OP_LMR)
      gcnt_d = CNT_W'(MODE_LOAD_DELAY);
    else if (issue && req_all)
      gcnt_d = CNT_W'(PRECHARGE_TIME);
  end

  // Bus address phase and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aph_valid_q <= 1'b0;
      aph_write_q <= 1'b0;
      aph_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce && hready)
    begin
      aph_valid_q <= ap_take;
      aph_write_q <= hwrite;
      aph_addr_q <= haddr[7:0];
      rdata_q <= rd_mux;
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_cke_q <= CTRL_CKE_RST;
      addr_q <= '0;
      cmd_q <= 9'h000;
      err_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_cke_q <= hwdata[CTRL_CKE_BIT];
      if (wr_addr)
        addr_q <= hwdata[ADDR_W-1:0];
      if (issue)
        cmd_q <= hwdata[8:0];
      err_q <= err_d; // Set wins over clear
    end
  end

  // Pins change only at the edge, held a whole cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pins <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                we_n: 1'b1, ba: 2'h0, addr: '0};
      gcnt_q <= '0;
    end
    else if (ce)
    begin
      pins <= pins_d;
      gcnt_q <= gcnt_d;
    end
  end

  // Bank of the most recent burst, for burst terminate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_bank_q <= 2'h0;
      last_valid_q <= 1'b0;
    end
    else if (ce && issue && req_rw)
    begin
      last_bank_q <= req_bank;
      last_valid_q <= 1'b1;
    end
  end

  // Checks on what the controller drives
  localparam int GB_MAX = REFRESH_CYCLE_TIME + 2;
  logic pin_quiet;
  logic pin_act;
  assign pin_quiet = pins.cs_n || ({pins.ras_n, pins.cas_n, pins.we_n} == 3'h7);
  assign pin_act = !pins.cs_n && !pins.ras_n && pins.cas_n && pins.we_n;

  a_act_to_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && req_op == OP_ACT) |-> sel_idle ##1
    (pin_act && bank_st[$past(req_bank)] == BK_ACTIVATING))
    else $error("ACTIVE sent to a bank that was not idle");

  a_rw_open_row: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && req_rw) |-> sel_open ##1
    (!pins.cs_n && pins.ras_n && !pins.cas_n))
    else $error("Column command without an open row");

  a_ap_flag_bit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && (req_rw || req_op == OP_PRE)) |=>
    pins.addr[AP_ADDR_BIT] == $past(req_ap))
    else $error("Auto precharge bit differs from request");

  a_ref_all_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && (req_op == OP_REF || req_op == OP_LMR)) |-> all_idle)
    else $error("Refresh or mode load with a bank not idle");

  a_refresh_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && req_op == OP_REF) |=> ##1 pin_quiet[*8])
    else $error("Command during refresh cycle time");

  a_mode_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && req_op == OP_LMR) |=> ##1 pin_quiet[*2])
    else $error("Command during mode load delay");

  a_pre_all_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && req_all) |-> all_pre_ok ##1 (gbusy && !issue))
    else $error("Precharge-all not followed by quiet time");

  a_busy_bounded: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    $rose(gbusy) |-> ##[1:GB_MAX] !gbusy)
    else $error("Quiet period never ends");

  a_cke_gate_ok: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (issue && req_op != OP_NOP) |=> (pins.cke && $past(pins.cke)))
    else $error("Command sent with clock enable low");

  a_refuse_sets_err: assert property (
    @(posedge hclk) disable iff (!hresetn)
    refuse |=> (err_q && pin_quiet))
    else $error("Refused command not flagged");

  a_one_cycle_cmd: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !issue) |=> pins.cs_n)
    else $error("Command pins left asserted");

  c_refresh: cover property (@(posedge hclk) issue && req_op == OP_REF);
  c_read_ap: cover property (@(posedge hclk) issue && req_op == OP_RD && req_ap);
  c_bst: cover property (@(posedge hclk) issue && req_op == OP_BST);
  c_refused: cover property (@(posedge hclk) refuse);
endmodule // sdrbc_host
`default_nettype wire

//--- verif/sdrbc_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdrbc_dev_model
  import sdrbc_pkg::*;
#(
  parameter int PRECHARGE_TIME = PRECHARGE_CYCLES,
  parameter int ACTIVATE_TO_ACCESS_DELAY = ACTIVATE_CYCLES,
  parameter int REFRESH_CYCLE_TIME = REFRESH_CYCLES,
  parameter int MODE_LOAD_DELAY = MODE_LOAD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire sdrbc_pins_t pins,
  output int bad_cnt
);
  sdrbc_bank_st_t st [BANKS];
  int cnt [BANKS];
  int quiet;
  logic cke_q;
  logic [1:0] last;
  // Pins count only when selected, with clock enable high on two edges
  wire logic live = cke_q && pins.cke && !pins.cs_n;
  wire logic [2:0] strb = {pins.ras_n, pins.cas_n, pins.we_n};
  wire logic [1:0] b = pins.ba;
  wire logic a10 = pins.addr[AP_ADDR_BIT];
  function automatic logic timed(input sdrbc_bank_st_t s);
    return s inside {BK_ACTIVATING, BK_PRECHARGING, BK_READ_AP, BK_WRITE_AP};
  endfunction
  // Accept a bank command or count it as illegal
  task automatic go(input logic c, input sdrbc_bank_st_t s, input int n);
    if (!c)
      bad_cnt++;
    else
    begin
      st[b] = s;
      cnt[b] = n;
    end
  endtask
  // Timers run out before decode, so a command on the final edge is legal
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st = '{default: BK_IDLE};
      cnt = '{default: 0};
      quiet = 0;
      cke_q = 1'b0;
      bad_cnt = 0;
      last = 2'h0;
    end
    else
    begin
      if (quiet > 0)
        quiet--;
      foreach (cnt[i])
        if (cnt[i] > 0)
        begin
          cnt[i]--;
          if (cnt[i] == 0)
            st[i] = (st[i] == BK_ACTIVATING) ? BK_ROW : BK_IDLE;
        end
      if (live && quiet > 0 && strb != 3'h7)
        bad_cnt++;
      else if (live)
        case (strb)
          3'h3: go(st[b] == BK_IDLE, BK_ACTIVATING, ACTIVATE_TO_ACCESS_DELAY);
          3'h5, 3'h4:
          begin
            go(st[b] inside {BK_ROW, BK_READ, BK_WRITE},
              a10 ? (strb[0] ? BK_READ_AP : BK_WRITE_AP) : (strb[0] ? BK_READ : BK_WRITE),
              a10 ? PRECHARGE_TIME : 0);
            last = b;
          end
          3'h2:
            if (a10)
            begin
              foreach (st[i])
              begin
                if (timed(st[i]))
                  bad_cnt++;
                st[i] = BK_PRECHARGING;
                cnt[i] = PRECHARGE_TIME;
              end
              quiet = PRECHARGE_TIME;
            end
            else if (st[b] != BK_IDLE)
              go(!timed(st[b]), BK_PRECHARGING, PRECHARGE_TIME);
          3'h6:
            if (st[last] inside {BK_READ, BK_WRITE})
              st[last] = BK_ROW;
          3'h1, 3'h0:
          begin
            foreach (st[i])
              if (st[i] != BK_IDLE)
                bad_cnt++;
            quiet = strb[0] ? REFRESH_CYCLE_TIME : MODE_LOAD_DELAY;
          end
          default: ;
        endcase
      cke_q = pins.cke;
    end
  end
endmodule // sdrbc_dev_model
`default_nettype wire

//--- verif/sdram_bank_command_fsm_test.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_bank_command_fsm_test
  import sdrbc_pkg::*;
;
  typedef struct packed {
    sdrbc_op_t op;
    logic [1:0] bank;
    logic ap;
    logic ok;
    logic [2:0] strb;
    logic [15:0] st;
  } sdrbc_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd_q;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  sdrbc_pins_t pins;
  logic [2:0] seen_strb;
  logic seen_a10;
  logic [14:0] seen_ba_addr;
  int bad_cnt;
  int failures = 0;
  int cmp_count = 0;
  int n_cmd = 0;
  int n0;
  // Idle, reject, plain and auto-precharge accesses, all-bank commands
  sdrbc_row_t rows [20] = '{
    '{OP_NOP, 2'h0, 1'b0, 1'b1, 3'h7, 16'h0000}, '{OP_ACT, 2'h0, 1'b0, 1'b1, 3'h3, 16'h0002},
    '{OP_ACT, 2'h0, 1'b0, 1'b0, 3'h0, 16'h0002}, '{OP_RD, 2'h0, 1'b0, 1'b1, 3'h5, 16'h0002},
    '{OP_WR, 2'h0, 1'b0, 1'b1, 3'h4, 16'h0002}, '{OP_RD, 2'h1, 1'b0, 1'b0, 3'h0, 16'h0002},
    '{OP_REF, 2'h0, 1'b0, 1'b0, 3'h0, 16'h0002}, '{OP_LMR, 2'h0, 1'b0, 1'b0, 3'h0, 16'h0002},
    '{OP_PRE, 2'h0, 1'b0, 1'b1, 3'h2, 16'h0000}, '{OP_PRE, 2'h2, 1'b0, 1'b1, 3'h2, 16'h0000},
    '{OP_ACT, 2'h1, 1'b0, 1'b1, 3'h3, 16'h0020}, '{OP_RD, 2'h1, 1'b1, 1'b1, 3'h5, 16'h0000},
    '{OP_ACT, 2'h1, 1'b0, 1'b1, 3'h3, 16'h0020}, '{OP_WR, 2'h1, 1'b1, 1'b1, 3'h4, 16'h0000},
    '{OP_REF, 2'h0, 1'b0, 1'b1, 3'h1, 16'h0000}, '{OP_LMR, 2'h0, 1'b0, 1'b1, 3'h0, 16'h0000},
    '{OP_ACT, 2'h3, 1'b0, 1'b1, 3'h3, 16'h2000}, '{OP_ACT, 2'h2, 1'b0, 1'b1, 3'h3, 16'h2200},
    '{OP_PRE, 2'h0, 1'b1, 1'b1, 3'h2, 16'h0000}, '{OP_WR, 2'h0, 1'b0, 1'b0, 3'h0, 16'h0000}};
  sdrbc_host sdrbc_host_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins(pins));
  sdrbc_dev_model sdrbc_dev_model_i (.hclk(hclk), .hresetn(hresetn), .pins(pins),
    .bad_cnt(bad_cnt));
  // 200 MHz clock
  always #2.5 hclk = ~hclk;
  // Commands the device would register at each edge
  always @(posedge hclk)
    if (pins.cke === 1'b1 && pins.cs_n === 1'b0)
    begin
      n_cmd <= n_cmd + 1;
      seen_strb <= {pins.ras_n, pins.cas_n, pins.we_n};
      seen_a10 <= pins.addr[AP_ADDR_BIT];
      seen_ba_addr <= {pins.ba, pins.addr};
    end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One AHB single transfer; holds each phase until hready is sampled high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_q = hrdata;
  endtask
  task automatic cmd(input sdrbc_op_t op, input logic [1:0] b, input logic ap);
    bus(REG_CMD, 1'b1, (32'(op) << CMD_OP_LSB) | (32'(b) << CMD_BANK_LSB) |
      (32'(ap) << CMD_AP_BIT));
  endtask
  // Poll status until no timed state or quiet period is left
  task automatic settle();
    logic done;
    done = 1'b0;
    for (int k = 0; k < 40 && !done; k++)
    begin
      bus(REG_STAT, 1'b0, 32'h0);
      done = (rd_q[0] === 1'b0);
      for (int i = 0; i < BANKS; i++)
        if (rd_q[4*i+4 +: 4] !== 4'h0 && rd_q[4*i+4 +: 4] !== 4'h2)
          done = 1'b0;
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog, well past the expected run length
  initial
  begin
    repeat (30000) @(posedge hclk);
    failures++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    chk("pins in reset", {1'b0, 4'hF, 15'h0}, pins);
    chk("bus in reset", 32'h2, {30'h0, hreadyout, hresp});
    chk("rdata in reset", 32'h0, hrdata);
    hresetn <= 1'b1;
    bus(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", {31'h0, CTRL_CKE_RST}, rd_q);
    bus(8'h10, 1'b1, 32'hFFFFFFFF);
    bus(8'h10, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd_q);
    $display("test reset done");
    foreach (rows[i])
    begin
      n0 = n_cmd;
      cmd(rows[i].op, rows[i].bank, rows[i].ap);
      settle();
      chk("bank states", 32'(rows[i].st), 32'(rd_q[19:4]));
      chk("refused", 32'(!rows[i].ok), 32'(rd_q[STAT_ERR_BIT]));
      chk("issued", n0 + rows[i].ok, n_cmd);
      if (rows[i].ok)
        chk("strobes", rows[i].strb, seen_strb);
      if (rows[i].ok && rows[i].op inside {OP_RD, OP_WR, OP_PRE})
        chk("addr bit ten", rows[i].ap, seen_a10);
      bus(REG_STAT, 1'b1, 32'h2);
    end
    $display("test rows done");
    n0 = n_cmd;
    cmd(OP_REF, 2'h0, 1'b0);
    bus(REG_STAT, 1'b0, 32'h0);
    chk("busy", 32'h1, {31'h0, rd_q[0]});
    cmd(OP_ACT, 2'h0, 1'b0);
    bus(REG_STAT, 1'b0, 32'h0);
    chk("quiet refuse", 32'h1, {31'h0, rd_q[STAT_ERR_BIT]});
    chk("quiet pins", n0 + 1, n_cmd);
    settle();
    bus(REG_STAT, 1'b1, 32'h2);
    // Column command while the row still opens; a status read between would be too late
    cmd(OP_ACT, 2'h0, 1'b0);
    cmd(OP_RD, 2'h0, 1'b0);
    bus(REG_STAT, 1'b0, 32'h0);
    chk("activating", 32'h1, {28'h0, rd_q[7:4]});
    chk("busy bank", 32'h1, {31'h0, rd_q[STAT_ERR_BIT]});
    settle();
    bus(REG_STAT, 1'b1, 32'h2);
    $display("test quiet done");
    // Precharge cuts a plain read, then a plain write
    for (int k = 0; k < 2; k++)
    begin
      cmd(k == 0 ? OP_RD : OP_WR, 2'h0, 1'b0);
      cmd(OP_PRE, 2'h0, 1'b0);
      bus(REG_STAT, 1'b0, 32'h0);
      chk("cut burst", 32'h7, {28'h0, rd_q[7:4]});
      settle();
      chk("after cut", 32'h0, {28'h0, rd_q[7:4]});
      cmd(OP_ACT, 2'h0, 1'b0);
      settle();
    end
    cmd(OP_ACT, 2'h1, 1'b0);
    settle();
    cmd(OP_RD, 2'h0, 1'b0);
    cmd(OP_WR, 2'h1, 1'b0);
    cmd(OP_BST, 2'h0, 1'b0);
    settle();
    chk("terminate", 32'h6, seen_strb);
    chk("banks open", 32'h22, {24'h0, rd_q[11:4]});
    // Address register reaches the pins, bit ten replaced by the request
    bus(REG_ADDR, 1'b1, 32'h1234_5678);
    bus(REG_ADDR, 1'b0, 32'h0);
    chk("addr reg", 32'h1678, rd_q);
    cmd(OP_PRE, 2'h1, 1'b0);
    bus(REG_CMD, 1'b0, 32'h0);
    chk("cmd reg", 32'h14, rd_q);
    chk("pins ba addr", 32'h3278, 32'(seen_ba_addr));
    $display("test burst done");
    bus(REG_CTRL, 1'b1, 32'h0);
    cmd(OP_PRE, 2'h0, 1'b1);
    bus(REG_STAT, 1'b0, 32'h0);
    chk("cke off", 32'h2, {29'h0, rd_q[2:0]});
    chk("cke pin", 32'h0, {31'h0, pins.cke});
    bus(REG_CTRL, 1'b1, 32'h1);
    n0 = n_cmd;
    ce <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("frozen", 32'h1, {31'h0, pins.cs_n});
    ce <= 1'b1;
    bus(REG_STAT, 1'b1, 32'h2);
    settle();
    chk("cke back", 32'h4, {29'h0, rd_q[2:0]});
    chk("no commands", n0, n_cmd);
    $display("test cke done");
    chk("device view", 32'h0, bad_cnt);
    give_verdict();
  end
endmodule // sdram_bank_command_fsm_test
`default_nettype wire
